// ===== rtl/video_pkg.sv
// package: register indices, field layouts, reset values and raster constants of the video generator
package video_pkg;

  // ****************************************************************
  // clock and register bus
  // ****************************************************************
  localparam int unsigned CLK_HZ  = 25_000_000;
  localparam int unsigned PADDR_W = 18;

  // register indices; the bus byte address is four times the index
  localparam logic [15:0] IDX_CTRL   = 16'hD001;
  localparam logic [15:0] IDX_COLORS = 16'hD002;
  localparam logic [15:0] IDX_BASE   = 16'hD003;
  localparam logic [15:0] IDX_SCROLL = 16'hD004;
  localparam logic [15:0] IDX_SPRITE = 16'hD006;
  localparam logic [15:0] IDX_STATUS = 16'hD008;
  localparam logic [15:0] IDX_FXCTRL = 16'hD040;
  localparam logic [15:0] IDX_FXDATA = 16'hD060;

  // reset values
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_COLORS = 8'hE7;
  localparam logic [7:0] RST_BASE   = 8'h95;
  localparam logic [7:0] RST_SCROLL = 8'h00;
  localparam logic [7:0] RST_SPRITE = 8'h00;

  // ****************************************************************
  // field layouts
  // ****************************************************************
  localparam int unsigned CTRL_VSCROLL = 1;
  localparam int unsigned CTRL_HSCROLL = 2;
  localparam int unsigned CTRL_FX_EN   = 3;
  localparam int unsigned CTRL_BITMAP  = 4;
  localparam int unsigned FX_ENTRIES   = 32;
  localparam int unsigned FX_ROW_W     = 5;
  localparam int unsigned FX_EN_BIT    = 5;

  // row effect destinations, also the index into the override array
  typedef enum logic [1:0] {
    DEST_BASE   = 2'b00,
    DEST_SCROLL = 2'b01,
    DEST_COLORS = 2'b10,
    DEST_SPRITE = 2'b11
  } fx_dest_t;

  // ****************************************************************
  // video memory and raster geometry
  // ****************************************************************
  localparam logic [15:0] VMEM_WINDOW   = 16'hA000;
  localparam logic [15:0] COLOR_MEM     = 16'hD800;
  localparam int unsigned SCREEN_SHIFT  = 10;
  localparam int unsigned CHARSET_SHIFT = 11;
  localparam logic [15:0] ROW_CELLS     = 16'h0028;
  localparam logic [15:0] ROW_BYTES     = 16'h0140;
  localparam logic [15:0] TILE_BYTES    = 16'h0008;
  localparam logic [15:0] CHAR_BYTES    = 16'h03E8;
  localparam logic [15:0] BITMAP_BYTES  = 16'h1F40;
  localparam logic [7:0]  H_ACTIVE      = 8'hA0;
  localparam logic [7:0]  H_TOTAL       = 8'hC8;
  localparam logic [7:0]  PREFETCH_X    = 8'hC4;
  localparam logic [7:0]  FX_EVAL_X     = 8'hC3;
  localparam logic [8:0]  V_ACTIVE      = 9'h0C8;
  localparam logic [8:0]  V_TOTAL       = 9'h106;

endpackage

// ===== rtl/video_core_if.sv
// interface: signals passed between the video generator core, its row effect unit and its address unit
`timescale 1ns/100ps
`default_nettype none
interface video_core_if;
  logic [7:0]  fx_ctrl [video_pkg::FX_ENTRIES];
  logic [7:0]  fx_data [video_pkg::FX_ENTRIES];
  logic [7:0]  orig    [4];
  logic [7:0]  eff     [4];
  logic        fx_on;
  logic        apply;
  logic        restart;
  logic [4:0]  next_row;
  logic        bitmap;
  logic [7:0]  base;
  logic [4:0]  row;
  logic [5:0]  col;
  logic [2:0]  line;
  logic [7:0]  code;
  logic [15:0] cell_addr;
  logic [15:0] glyph_addr;
  logic [15:0] color_addr;

  modport fx   (input fx_ctrl, fx_data, orig, fx_on, apply, restart, next_row, output eff);
  modport addr (input bitmap, base, row, col, line, code, output cell_addr, glyph_addr, color_addr);
  modport core (output fx_ctrl, fx_data, orig, fx_on, apply, restart, next_row,
                output bitmap, base, row, col, line, code,
                input eff, cell_addr, glyph_addr, color_addr);
endinterface
`default_nettype wire

// ===== rtl/row_effect_unit.sv
// row effect unit: holds the per-frame working copies of base, scroll, colors and sprite registers
`timescale 1ns/100ps
`default_nettype none
module row_effect_unit (
  input wire logic    clk,
  input wire logic    rst_n,
  video_core_if.fx    vif
);

  logic [7:0] eff_r   [4];
  logic [7:0] eff_nxt [4];

  // start from the original values on row 0, otherwise keep what the frame built up
  always_comb begin
    for (int d = 0; d < 4; d++) begin
      eff_nxt[d] = vif.restart ? vif.orig[d] : eff_r[d];
    end
    // ascending scan: a later entry overwrites an earlier one for the same target
    for (int i = 0; i < video_pkg::FX_ENTRIES; i++) begin
      if (vif.fx_on && vif.fx_ctrl[i][video_pkg::FX_EN_BIT] &&
          (vif.fx_ctrl[i][video_pkg::FX_ROW_W-1:0] == vif.next_row)) begin
        eff_nxt[vif.fx_ctrl[i][7:6]] = vif.fx_data[i];
      end
    end
  end

  // copies change only at a row boundary, so one sprite bank per row
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eff_r <= '{video_pkg::RST_BASE, video_pkg::RST_SCROLL, video_pkg::RST_COLORS, video_pkg::RST_SPRITE};
    end else if (vif.apply) begin
      eff_r <= eff_nxt;
    end
  end

  assign vif.eff = eff_r;

endmodule
`default_nettype wire

// ===== rtl/tile_addr.sv
// tile address unit: video memory addresses for screen codes, glyph or bitmap bytes and color cells
`timescale 1ns/100ps
`default_nettype none
module tile_addr (
  video_core_if.addr vif
);

  // cell number inside a 40 by 25 map, shared by screen and color memory
  function automatic logic [15:0] cell_index(input logic [4:0] row, input logic [5:0] col);
    return 16'(16'(row) * video_pkg::ROW_CELLS) + 16'(col);
  endfunction

  wire logic [15:0] screen_base;
  wire logic [15:0] charset_base;
  wire logic [15:0] bitmap_byte;
  wire logic [15:0] glyph_byte;

  // high nibble selects screen memory in 1 KiB steps, low nibble the glyph set in 2 KiB steps
  assign screen_base  = video_pkg::VMEM_WINDOW + 16'({12'h000, vif.base[7:4]} << video_pkg::SCREEN_SHIFT);
  assign charset_base = video_pkg::VMEM_WINDOW + 16'({12'h000, vif.base[3:0]} << video_pkg::CHARSET_SHIFT);

  // bitmap: 320 bytes per tile row, 8 bytes per 4x8 tile, one byte per line, 8000 bytes in all
  assign bitmap_byte = screen_base + 16'(16'(vif.row) * video_pkg::ROW_BYTES)
                     + 16'(16'(vif.col) * video_pkg::TILE_BYTES) + 16'(vif.line);
  // character mode: eight bytes per glyph, one per pixel line
  assign glyph_byte  = charset_base + 16'(16'(vif.code) * video_pkg::TILE_BYTES) + 16'(vif.line);

  assign vif.cell_addr  = screen_base + cell_index(vif.row, vif.col);
  assign vif.glyph_addr = vif.bitmap ? bitmap_byte : glyph_byte;
  assign vif.color_addr = video_pkg::COLOR_MEM + cell_index(vif.row, vif.col);

endmodule
`default_nettype wire

// ===== rtl/video_generator.sv
// video generator: APB registers, row effects, raster timing, tile fetch and pixel output
`timescale 1ns/100ps
`default_nettype none
module video_generator (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [video_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  output var  logic [15:0]                   vmem_addr,
  input  wire logic [7:0]                    vmem_rdata,
  output var  logic                          pixel_valid,
  output var  logic [3:0]                    pixel_color,
  output var  logic                          frame_start,
  output var  logic [3:0]                    sprite_bank,
  output var  logic [3:0]                    sprite_color
);

  // ****************************************************************
  // registers seen by software
  // ****************************************************************
  logic [7:0]  ctrl_r;
  logic [7:0]  colors_r;
  logic [7:0]  base_r;
  logic [7:0]  scroll_r;
  logic [7:0]  sprite_r;
  logic [7:0]  fx_ctrl_r [video_pkg::FX_ENTRIES];
  logic [7:0]  fx_data_r [video_pkg::FX_ENTRIES];
  logic [31:0] prdata_r;

  // ****************************************************************
  // raster and fetch state
  // ****************************************************************
  logic [7:0]  x_r;
  logic [8:0]  y_r;
  logic [7:0]  pat_fetch_r;
  logic [7:0]  cur_pat_r;
  logic [7:0]  prev_pat_r;
  logic [7:0]  cur_col_r;
  logic [7:0]  prev_col_r;
  logic        pixel_valid_r;
  logic [3:0]  pixel_color_r;
  logic        frame_start_r;

  video_core_if vif ();

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic [15:0] idx;
  wire logic        aligned;
  wire logic        hit_ctrl;
  wire logic        hit_colors;
  wire logic        hit_base;
  wire logic        hit_scroll;
  wire logic        hit_sprite;
  wire logic        hit_status;
  wire logic        hit_fxctrl;
  wire logic        hit_fxdata;
  wire logic        mapped;
  wire logic        setup;
  wire logic        access;
  wire logic        wr_en;
  wire logic [4:0]  entry;
  wire logic [7:0]  rd_byte;

  // every register is one aligned word; the index sits in address bits 17:2
  assign idx        = paddr[video_pkg::PADDR_W-1:2];
  assign aligned    = (paddr[1:0] == 2'b00);
  assign entry      = idx[4:0];
  assign hit_ctrl   = aligned && (idx == video_pkg::IDX_CTRL);
  assign hit_colors = aligned && (idx == video_pkg::IDX_COLORS);
  assign hit_base   = aligned && (idx == video_pkg::IDX_BASE);
  assign hit_scroll = aligned && (idx == video_pkg::IDX_SCROLL);
  assign hit_sprite = aligned && (idx == video_pkg::IDX_SPRITE);
  assign hit_status = aligned && (idx == video_pkg::IDX_STATUS);
  assign hit_fxctrl = aligned && (idx[15:5] == video_pkg::IDX_FXCTRL[15:5]);
  assign hit_fxdata = aligned && (idx[15:5] == video_pkg::IDX_FXDATA[15:5]);
  assign mapped     = hit_ctrl || hit_colors || hit_base || hit_scroll || hit_sprite
                   || hit_status || hit_fxctrl || hit_fxdata;
  assign setup      = psel && !penable;
  assign access     = psel && penable;
  // status is read only; writing it is an error like an unmapped address
  assign wr_en      = access && pwrite && mapped && !hit_status;

  // read data is chosen during setup so the access phase needs no wait state
  assign rd_byte = hit_ctrl   ? ctrl_r :
                   hit_colors ? colors_r :
                   hit_base   ? base_r :
                   hit_scroll ? scroll_r :
                   hit_sprite ? sprite_r :
                   hit_fxctrl ? fx_ctrl_r[entry] :
                   hit_fxdata ? fx_data_r[entry] : 8'h00;

  // every register answers in its access cycle, so pready never drops
  assign pready  = 1'b1;
  assign pslverr = access && (!mapped || (pwrite && hit_status));
  assign prdata  = prdata_r;

  // single-register writes; only the low byte lane carries data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= video_pkg::RST_CTRL;
      colors_r <= video_pkg::RST_COLORS;
      base_r   <= video_pkg::RST_BASE;
      scroll_r <= video_pkg::RST_SCROLL;
      sprite_r <= video_pkg::RST_SPRITE;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        ctrl_r <= pwdata[7:0];
      end
      if (hit_colors) begin
        colors_r <= pwdata[7:0];
      end
      if (hit_base) begin
        base_r <= pwdata[7:0];
      end
      if (hit_scroll) begin
        scroll_r <= pwdata[7:0];
      end
      if (hit_sprite) begin
        sprite_r <= pwdata[7:0];
      end
    end
  end

  // row effect banks; entries reset cleared so nothing fires by accident
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fx_ctrl_r <= '{default: 8'h00};
      fx_data_r <= '{default: 8'h00};
    end else if (wr_en) begin
      if (hit_fxctrl) begin
        fx_ctrl_r[entry] <= pwdata[7:0];
      end
      if (hit_fxdata) begin
        fx_data_r[entry] <= pwdata[7:0];
      end
    end
  end

  // status shows the raster line the generator is on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= hit_status ? {23'h000000, y_r} : {24'h000000, rd_byte};
    end
  end

  // ****************************************************************
  // raster timing
  // ****************************************************************
  wire logic       line_end;
  wire logic       frame_end;
  wire logic [8:0] y_next;

  assign line_end  = (x_r == video_pkg::H_TOTAL - 8'h01);
  assign frame_end = line_end && (y_r == video_pkg::V_TOTAL - 9'h001);
  assign y_next    = (y_r == video_pkg::V_TOTAL - 9'h001) ? 9'h000 : y_r + 9'h001;

  // free-running 200 by 262 raster, active area 160 by 200
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_r           <= 8'h00;
      y_r           <= 9'h000;
      frame_start_r <= 1'b0;
    end else begin
      x_r           <= line_end ? 8'h00 : x_r + 8'h01;
      y_r           <= line_end ? y_next : y_r;
      frame_start_r <= frame_end;
    end
  end

  // ****************************************************************
  // row effects
  // ****************************************************************
  wire logic       row_edge;
  wire logic [7:0] eff_scroll;
  wire logic [7:0] eff_colors;
  wire logic [7:0] eff_sprite;

  // evaluate one cycle before the prefetch of the next line so new values steer its first tile
  assign row_edge    = (x_r == video_pkg::FX_EVAL_X) && (y_next[2:0] == 3'b000)
                    && (y_next < video_pkg::V_ACTIVE);
  assign vif.fx_ctrl = fx_ctrl_r;
  assign vif.fx_data = fx_data_r;
  assign vif.orig    = '{base_r, scroll_r, colors_r, sprite_r};
  assign vif.fx_on   = ctrl_r[video_pkg::CTRL_FX_EN];
  assign vif.apply   = row_edge;
  // limitation: host writes to the originals only show from the next frame's row 0
  assign vif.restart = (y_next == 9'h000);
  assign vif.next_row = y_next[7:3];

  // per-frame working copies; they move only at a row boundary, never mid-row
  row_effect_unit u_fx (
    .clk   (clk),
    .rst_n (rst_n),
    .vif   (vif)
  );

  // working copies after row effects, indexed by destination code
  assign eff_scroll = vif.eff[video_pkg::DEST_SCROLL];
  assign eff_colors = vif.eff[video_pkg::DEST_COLORS];
  assign eff_sprite = vif.eff[video_pkg::DEST_SPRITE];

  // sprite bank in the high nibble, shared sprite color in the low nibble
  assign sprite_bank  = eff_sprite[7:4];
  assign sprite_color = eff_sprite[3:0];

  // ****************************************************************
  // tile fetch
  // ****************************************************************
  wire logic [1:0] phase;
  wire logic       prefetch;
  wire logic [8:0] fetch_y;
  wire logic [2:0] v_fine;
  wire logic [1:0] h_fine;
  wire logic [8:0] src_y_raw;
  wire logic [8:0] src_y;
  wire logic       bitmap_mode;

  // scroll values only act when their own enables are set
  assign v_fine = ctrl_r[video_pkg::CTRL_VSCROLL] ? eff_scroll[2:0] : 3'b000;
  assign h_fine = ctrl_r[video_pkg::CTRL_HSCROLL] ? eff_scroll[5:4] : 2'b00;
  assign bitmap_mode = ctrl_r[video_pkg::CTRL_BITMAP];

  // each tile is fetched during the four pixels before it is shown
  assign phase     = x_r[1:0];
  assign prefetch  = (x_r >= video_pkg::PREFETCH_X);
  assign fetch_y   = prefetch ? y_next : y_r;
  assign src_y_raw = fetch_y + {6'h00, v_fine};
  // vertical scroll wraps inside the 200 visible lines
  assign src_y     = (src_y_raw >= video_pkg::V_ACTIVE) ? src_y_raw - video_pkg::V_ACTIVE : src_y_raw;

  // address unit inputs: tile row and pixel line come from the scrolled source line
  assign vif.bitmap = bitmap_mode;
  assign vif.base   = vif.eff[video_pkg::DEST_BASE];
  assign vif.row    = src_y[7:3];
  assign vif.line   = src_y[2:0];
  assign vif.col    = prefetch ? 6'h00 : 6'(x_r[7:2] + 6'h01);
  assign vif.code   = vmem_rdata;

  // purely combinational, so the address is ready in the same fetch phase
  tile_addr u_addr (
    .vif (vif)
  );

  // phase 0 screen code, phase 1 glyph or bitmap byte, phase 2 color cell; read data lands one cycle later
  assign vmem_addr = (phase == 2'b01) ? vif.glyph_addr :
                     (phase == 2'b10) ? vif.color_addr : vif.cell_addr;

  // the pattern arrives in phase 2 and the color in phase 3, then both become the current tile
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pat_fetch_r <= 8'h00;
      cur_pat_r   <= 8'h00;
      prev_pat_r  <= 8'h00;
      cur_col_r   <= 8'h00;
      prev_col_r  <= 8'h00;
    end else begin
      if (phase == 2'b10) begin
        pat_fetch_r <= vmem_rdata;
      end
      if (phase == 2'b11) begin
        prev_pat_r <= cur_pat_r;
        prev_col_r <= cur_col_r;
        cur_pat_r  <= pat_fetch_r;
        cur_col_r  <= vmem_rdata;
      end
    end
  end

  // ****************************************************************
  // pixel output
  // ****************************************************************
  wire logic [2:0] pick;
  wire logic       use_prev;
  wire logic [1:0] slot;
  wire logic [7:0] pat_sel;
  wire logic [7:0] col_sel;
  wire logic [1:0] pix_code;
  wire logic [3:0] pix_color;
  wire logic       active;

  // horizontal fine scroll delays the tile stream by up to three pixels
  assign pick     = {1'b0, phase} - {1'b0, h_fine};
  assign use_prev = pick[2];
  assign slot     = pick[1:0];
  assign pat_sel  = use_prev ? prev_pat_r : cur_pat_r;
  assign col_sel  = use_prev ? prev_col_r : cur_col_r;
  // top bit pair is the leftmost of the four pixels
  assign pix_code = pat_sel[7 - 2*slot -: 2];
  // two shared colors from the colors register, two from the cell, in both modes
  assign pix_color = (pix_code == 2'b00) ? eff_colors[3:0] :
                     (pix_code == 2'b01) ? col_sel[7:4] :
                     (pix_code == 2'b10) ? col_sel[3:0] : eff_colors[7:4];
  assign active    = (x_r < video_pkg::H_ACTIVE) && (y_r < video_pkg::V_ACTIVE);

  // colour forced to 0 outside the active area so the border stays dark
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_valid_r <= 1'b0;
      pixel_color_r <= 4'h0;
    end else begin
      pixel_valid_r <= active;
      pixel_color_r <= active ? pix_color : 4'h0;
    end
  end

  // outputs straight from flip-flops
  assign pixel_valid = pixel_valid_r;
  assign pixel_color = pixel_color_r;
  assign frame_start = frame_start_r;

endmodule
`default_nettype wire

// ===== tb/vmem_model.sv
// partner: synchronous video memory answering one cycle after each address
`timescale 1ns/100ps
`default_nettype none
module vmem_model (
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  output var  logic [7:0]  rdata
);
  // content is a hash of the address, so every fetch has a known answer
  always_ff @(posedge clk) begin
    rdata <= addr[7:0] ^ addr[15:8];
  end
endmodule
`default_nettype wire

// ===== tb/video_generator_monitor.sv
// checker: port-level assertions for the video generator
`timescale 1ns/100ps
`default_nettype none
module video_generator_monitor (
  input wire logic                          clk,
  input wire logic                          rst_n,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [video_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic                          pixel_valid,
  input wire logic [3:0]                    pixel_color,
  input wire logic                          frame_start,
  input wire logic [3:0]                    sprite_bank,
  input wire logic [3:0]                    sprite_color
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // helper counters: frame length and active run length
  // ****************************************************************
  logic [16:0] gap_r;
  logic        seen_r;
  logic [8:0]  run_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 17'h00000;
      seen_r <= 1'b0;
      run_r <= 9'h000;
    end else begin
      gap_r <= frame_start ? 17'h00001 : gap_r + 17'h00001;
      seen_r <= seen_r | frame_start;
      run_r <= pixel_valid ? run_r + 9'h001 : 9'h000;
    end
  end
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned taken");
  a_err_nodata: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0) else $error("refused read data");
  a_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:9] == 23'h0) else $error("read upper bits set");
  a_frame_pulse: assert property (frame_start |=> !frame_start) else $error("frame pulse too long");
  a_frame_period: assert property (frame_start && seen_r |-> gap_r == 17'h0CCB0) else $error("frame length");
  a_line_width: assert property ($fell(pixel_valid) |-> run_r == 9'h0A0) else $error("active line width");
  a_dark_border: assert property (!pixel_valid |-> pixel_color == 4'h0) else $error("colour outside area");
  a_bank_steady: assert property ($changed({sprite_bank, sprite_color}) |-> !pixel_valid) else $error("mid row bank");
endmodule
bind video_generator video_generator_monitor u_mon (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .pixel_valid, .pixel_color, .frame_start, .sprite_bank, .sprite_color);
`default_nettype wire

// ===== tb/tb.sv
// testbench: registers, sprite row effects and frame restart of the video generator
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [video_pkg::PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pixel_valid, frame_start;
  logic [15:0] vmem_addr;
  logic [7:0] vmem_rdata;
  logic [3:0] pixel_color, sprite_bank, sprite_color;
  int error_cnt = 0, samples_checked = 0, cyc = 0, t0 = 0, spr = 0, spr_w = 0, pos = 0, a_exp = 0;
  logic bm = 1'b0;
  int fx_c[32], fx_d[32], used[$];
  always #20 clk = ~clk;
  always @(posedge clk) cyc++;
  video_generator u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .vmem_addr, .vmem_rdata, .pixel_valid, .pixel_color, .frame_start, .sprite_bank, .sprite_color);
  vmem_model u_mem (.clk, .addr(vmem_addr), .rdata(vmem_rdata));
  // ****************************************************************
  // shared tasks and the reference model
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // raster position from frame_start; bitmap byte at tile row y/8, next column x/4+1, line y mod 8
  always @(posedge clk) begin
    a_exp = video_pkg::VMEM_WINDOW + (video_pkg::RST_BASE[7:4] << video_pkg::SCREEN_SHIFT)
          + pos / 1600 * 320 + (pos % 200 / 4 + 1) * 8 + pos / 200 % 8;
    if (bm && pos < 40000 && pos % 200 < 156 && pos % 4 == 1)
      check("bitmap address", vmem_addr, a_exp);
    pos <= !rst_n ? 0 : frame_start ? 1 : pos + 1;
  end
  // one apb transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] idx, input int wd, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd[7:0]};
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count is assumed: only the watchdog ends a wait that never completes
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // effective sprite register at a row, effects active from row 'from'
  function automatic int exp_spr(int row, int from);
    int v;
    v = spr;
    for (int r = from; r <= row; r++)
      foreach (used[i])
        if (fx_c[used[i]][5] && fx_c[used[i]][4:0] == r && fx_c[used[i]][7:6] == 3) v = fx_d[used[i]];
    return v;
  endfunction
  task automatic sync_frame();
    while (frame_start !== 1'b1 && cyc - t0 < 60000) @(posedge clk);
    check("frame start", frame_start, 1);
    t0 = cyc;
  endtask
  task automatic row_check(int r, int from);
    while (cyc - t0 < (8 * r + 4) * 200) @(posedge clk);
    check("sprite bank", sprite_bank, exp_spr(r, from) >> 4);
    check("sprite colour", sprite_color, exp_spr(r, from) & 15);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one frame of 52,400 cycles plus 24 rows of the next take about 90,000 cycles
  initial begin
    repeat (98000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] rd;
    logic err;
    logic [15:0] ridx[5] = '{video_pkg::IDX_CTRL, video_pkg::IDX_COLORS, video_pkg::IDX_BASE,
                             video_pkg::IDX_SCROLL, video_pkg::IDX_SPRITE};
    logic [7:0] rexp[5] = '{video_pkg::RST_CTRL, video_pkg::RST_COLORS, video_pkg::RST_BASE,
                            video_pkg::RST_SCROLL, video_pkg::RST_SPRITE};
    int ec[5] = '{8'hEF, 8'hEF, 8'hD2, 8'hB2, 8'hF5}; // two writers on row 15, disabled, colours, row 21
    void'($urandom(91721));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t0 = cyc; // the first frame starts at reset release
    foreach (ridx[i]) begin
      apb(1'b0, ridx[i], 0, rd, err);
      check("reset value", rd, {24'h0, rexp[i]});
    end
    apb(1'b0, 16'hD000, 0, rd, err);
    check("unmapped error", err, 1);
    check("unmapped data", rd, 0);
    apb(1'b1, video_pkg::IDX_STATUS, 0, rd, err);
    check("status write error", err, 1);
    $display("test registers done");
    spr_w = $urandom & 255;
    spr = video_pkg::RST_SPRITE; // the written value only shows from the next frame
    apb(1'b1, video_pkg::IDX_SPRITE, spr_w, rd, err);
    foreach (ec[e]) begin
      fx_c[e] = ec[e];
      fx_d[e] = $urandom & 255;
      used.push_back(e);
      apb(1'b1, video_pkg::IDX_FXCTRL + 16'(e), fx_c[e], rd, err);
      apb(1'b1, video_pkg::IDX_FXDATA + 16'(e), fx_d[e], rd, err);
    end
    // effects still off globally: the row 15 entries must not reach row 16
    row_check(16, 99);
    apb(1'b1, video_pkg::IDX_CTRL, 8'h18, rd, err);
    bm = 1'b1;
    apb(1'b0, video_pkg::IDX_CTRL, 0, rd, err);
    check("control readback", rd, 32'h18);
    row_check(22, 17);
    $display("test effect enable done");
    sync_frame();
    spr = spr_w;
    row_check(1, 99);
    $display("test frame restart done");
    foreach (used[i]) row_check(14 + 2 * i + (i > 1), 0); // rows 14 16 19 21 23
    $display("test row effects done");
    conclude();
  end
endmodule
`default_nettype wire
